/* File: rtl/calu_pkg.sv */
// What this block does
// - zero flag follows zero result
// - carry flag records carry out
// - register adds write sum, update Z C N V H
// - word add/subtract immediate, update Z C N V S
// - subtracts write difference, update Z C N V H
// - and/or/xor update Z N V only
// - set and clear mask bits, update Z N V
// - test ands register with itself
// - pointer jump loads pc from Z, two cycles
// - pointer call pushes return, three cycles
// - compare skip equal, one/two/three cycles
// - compares load difference into res_r without res_we, update flags
// - skip on register bit state
// - skip on io bit state, flags untouched
// - generic flag branch adds offset plus one
// - branch on carry set or clear
// - unsigned branches test carry
// - signed branches test N xor V
// - branches on half carry state
// - branches on copy bit state
// - branch on overflow set
// - sign flag always N xor V
// - interrupt clears I, interrupt return sets
`default_nettype none

package calu_pkg;

  // ---------------------------------------------------------------
  // status flag bit positions
  // ---------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_FLAGS  = 12'h000;
  localparam logic [11:0] ADDR_PC     = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam logic [2:0] CYC_ONE       = 3'h1;
  localparam logic [2:0] CYC_BR_TAKEN  = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE  = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO  = 3'h3;
  localparam logic [2:0] CYC_PTR_JUMP  = 3'h2;
  localparam logic [2:0] CYC_PTR_CALL  = 3'h3;
  localparam logic [2:0] CYC_RETURN    = 3'h4;

  typedef enum logic [5:0] {
    op_nop, op_add, op_add_carry, op_word_add_immediate, op_sub,
    op_subtract_constant, op_subtract_borrow_reg, op_subtract_borrow_const,
    op_word_subtract_immediate, op_and, op_and_constant, op_or, op_or_constant,
    op_exclusive_or_regs, op_set_mask_bits, op_clear_mask_bits, op_zero_minus_test,
    op_pointer_jump, op_pointer_subroutine_call, op_sub_return, op_interrupt_return,
    op_compare_skip_equal, op_compare, op_compare_carry, op_compare_immediate,
    op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
    op_branch_flag_set, op_branch_flag_clear, op_branch_carry_set, op_branch_carry_clear,
    op_branch_unsigned_higher_same, op_branch_unsigned_lower, op_branch_signed_ge,
    op_branch_signed_less, op_branch_halfcarry_set, op_branch_halfcarry_clear,
    op_branch_copybit_set, op_branch_copybit_clear, op_branch_overflow_set
  } calu_op_t;

endpackage

`default_nettype wire

/* File: rtl/calu_exec.sv */
// Decided for this implementation: the APB slave port and the register offsets.
`default_nettype none

module calu_exec (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               op_valid,
  input  wire calu_pkg::calu_op_t op_code,
  input  wire logic [7:0]         opd_a,
  input  wire logic [7:0]         opd_b,
  input  wire logic [15:0]        word_in,
  input  wire logic [15:0]        z_ptr,
  input  wire logic [11:0]        rel_offset,
  input  wire logic [2:0]         sel_bit,
  input  wire logic [7:0]         io_val,
  input  wire logic               next_two_word,
  input  wire logic [15:0]        ret_addr,
  input  wire logic               irq_take,
  output logic                    op_ready,
  output logic [7:0]              res_data,
  output logic                    res_we,
  output logic [15:0]             word_data,
  output logic                    word_we,
  output logic [15:0]             pc,
  output logic                    push_we,
  output logic [15:0]             push_data,
  output logic                    pop_req,
  output logic [7:0]              flags_out
);

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  // returns {h, v, n, z, c, result}
  function automatic logic [12:0] arith8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin,
                                         input logic       sub);
    logic [8:0] s;
    logic [4:0] lo;
    logic       v;
    s  = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
             : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    lo = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
             : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
    v  = sub ? ((a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]))
             : ((a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]));
    return {lo[4], v, s[7], s[7:0] == 8'h00, s[8], s[7:0]};
  endfunction

  // returns {v, n, z, c, result}
  function automatic logic [19:0] arith16(input logic [15:0] w,
                                          input logic [7:0]  k,
                                          input logic        sub);
    logic [16:0] s;
    logic        v;
    s = sub ? ({1'b0, w} - {9'h000, k}) : ({1'b0, w} + {9'h000, k});
    v = sub ? (w[15] & ~s[15]) : (~w[15] & s[15]);
    return {v, s[15], s[15:0] == 16'h0000, s[16], s[15:0]};
  endfunction

  logic [7:0]  flags_r;
  logic [15:0] pc_r;
  logic [2:0]  busy_cnt_r;
  logic        op_ready_r;
  logic [7:0]  res_r;
  logic        res_we_r;
  logic [15:0] word_r;
  logic        word_we_r;
  logic        push_we_r;
  logic [15:0] push_data_r;
  logic        pop_req_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  logic        accept;
  logic        apb_setup;
  logic        apb_wr;
  logic        apb_hit;

  assign accept    = op_valid & op_ready_r;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign apb_hit   = (paddr == calu_pkg::ADDR_FLAGS) | (paddr == calu_pkg::ADDR_PC) |
                     (paddr == calu_pkg::ADDR_RESULT);

  // ---------------------------------------------------------------
  // execute decode
  // ---------------------------------------------------------------
  logic [7:0]  res_nxt;
  logic        res_we_nxt;
  logic [15:0] word_nxt;
  logic        word_we_nxt;
  logic [15:0] pc_nxt;
  logic [2:0]  cyc_nxt;
  logic [7:0]  fl_val;
  logic [7:0]  fl_mask;
  logic        push_nxt;
  logic        pop_nxt;
  logic        taken;
  logic        is_branch;
  logic        skip;

  always_comb begin
    logic [12:0] ar;
    logic [19:0] wr;
    logic [7:0]  lg;
    logic [15:0] seq;
    ar          = 13'h0000;
    wr          = 20'h00000;
    lg          = 8'h00;
    seq         = pc_r + 16'h0001;
    res_nxt     = 8'h00;
    res_we_nxt  = 1'b0;
    word_nxt    = 16'h0000;
    word_we_nxt = 1'b0;
    pc_nxt      = seq;
    cyc_nxt     = calu_pkg::CYC_ONE;
    fl_val      = 8'h00;
    fl_mask     = 8'h00;
    push_nxt    = 1'b0;
    pop_nxt     = 1'b0;
    taken       = 1'b0;
    is_branch   = 1'b0;
    skip        = 1'b0;
    unique case (op_code)
      calu_pkg::op_add, calu_pkg::op_add_carry: begin
        ar = arith8(opd_a, opd_b, (op_code == calu_pkg::op_add_carry) &
                    flags_r[calu_pkg::FLAG_C], 1'b0);
        res_we_nxt = 1'b1;
      end
      calu_pkg::op_sub, calu_pkg::op_subtract_constant, calu_pkg::op_subtract_borrow_reg,
      calu_pkg::op_subtract_borrow_const: begin
        ar = arith8(opd_a, opd_b, flags_r[calu_pkg::FLAG_C] &
                    ((op_code == calu_pkg::op_subtract_borrow_reg) |
                     (op_code == calu_pkg::op_subtract_borrow_const)), 1'b1);
        res_we_nxt = 1'b1;
      end
      calu_pkg::op_compare, calu_pkg::op_compare_immediate, calu_pkg::op_compare_carry: begin
        // difference feeds the flags and res_r, res_we stays low
        ar = arith8(opd_a, opd_b, (op_code == calu_pkg::op_compare_carry) &
                    flags_r[calu_pkg::FLAG_C], 1'b1);
      end
      calu_pkg::op_word_add_immediate, calu_pkg::op_word_subtract_immediate: begin
        wr = arith16(word_in, {2'b00, opd_b[5:0]},
                     op_code == calu_pkg::op_word_subtract_immediate);
        word_nxt    = wr[15:0];
        word_we_nxt = 1'b1;
        fl_mask     = 8'h1f;
        fl_val      = {3'b000, wr[19] ^ wr[18], wr[19], wr[18], wr[17], wr[16]};
      end
      calu_pkg::op_and, calu_pkg::op_and_constant, calu_pkg::op_zero_minus_test,
      calu_pkg::op_clear_mask_bits: begin
        lg = opd_a & ((op_code == calu_pkg::op_clear_mask_bits) ? ~opd_b :
                      (op_code == calu_pkg::op_zero_minus_test) ? opd_a : opd_b);
        res_we_nxt = (op_code != calu_pkg::op_zero_minus_test);
      end
      calu_pkg::op_or, calu_pkg::op_or_constant, calu_pkg::op_set_mask_bits: begin
        lg         = opd_a | opd_b;
        res_we_nxt = 1'b1;
      end
      calu_pkg::op_exclusive_or_regs: begin
        lg         = opd_a ^ opd_b;
        res_we_nxt = 1'b1;
      end
      calu_pkg::op_pointer_jump: begin
        pc_nxt  = z_ptr;
        cyc_nxt = calu_pkg::CYC_PTR_JUMP;
      end
      calu_pkg::op_pointer_subroutine_call: begin
        pc_nxt   = z_ptr;
        push_nxt = 1'b1;
        cyc_nxt  = calu_pkg::CYC_PTR_CALL;
      end
      calu_pkg::op_sub_return, calu_pkg::op_interrupt_return: begin
        pc_nxt  = ret_addr;
        pop_nxt = 1'b1;
        cyc_nxt = calu_pkg::CYC_RETURN;
      end
      calu_pkg::op_compare_skip_equal: skip = (opd_a == opd_b);
      calu_pkg::op_skip_reg_bit_clear: skip = ~opd_a[sel_bit];
      calu_pkg::op_skip_reg_bit_set:   skip = opd_a[sel_bit];
      calu_pkg::op_skip_io_bit_clear:  skip = ~io_val[sel_bit];
      calu_pkg::op_skip_io_bit_set:    skip = io_val[sel_bit];
      calu_pkg::op_nop: pc_nxt = seq;
      default: begin
        is_branch = 1'b1;
        unique case (op_code)
          calu_pkg::op_branch_flag_set:   taken = flags_r[sel_bit];
          calu_pkg::op_branch_flag_clear: taken = ~flags_r[sel_bit];
          calu_pkg::op_branch_carry_set, calu_pkg::op_branch_unsigned_lower:
            taken = flags_r[calu_pkg::FLAG_C];
          calu_pkg::op_branch_carry_clear, calu_pkg::op_branch_unsigned_higher_same:
            taken = ~flags_r[calu_pkg::FLAG_C];
          calu_pkg::op_branch_signed_ge:
            taken = ~(flags_r[calu_pkg::FLAG_N] ^ flags_r[calu_pkg::FLAG_V]);
          calu_pkg::op_branch_signed_less:
            taken = flags_r[calu_pkg::FLAG_N] ^ flags_r[calu_pkg::FLAG_V];
          calu_pkg::op_branch_halfcarry_set:   taken = flags_r[calu_pkg::FLAG_H];
          calu_pkg::op_branch_halfcarry_clear: taken = ~flags_r[calu_pkg::FLAG_H];
          calu_pkg::op_branch_copybit_set:     taken = flags_r[calu_pkg::FLAG_T];
          calu_pkg::op_branch_copybit_clear:   taken = ~flags_r[calu_pkg::FLAG_T];
          calu_pkg::op_branch_overflow_set:    taken = flags_r[calu_pkg::FLAG_V];
          default: taken = 1'b0;
        endcase
        if (taken) begin
          pc_nxt  = seq + {{4{rel_offset[11]}}, rel_offset};
          cyc_nxt = calu_pkg::CYC_BR_TAKEN;
        end
      end
    endcase
    if (skip) begin
      pc_nxt  = seq + (next_two_word ? 16'h0002 : 16'h0001);
      cyc_nxt = next_two_word ? calu_pkg::CYC_SKIP_TWO : calu_pkg::CYC_SKIP_ONE;
    end
    // 8-bit arithmetic class: Z C N V H
    if (ar != 13'h0000 || op_code inside {calu_pkg::op_add, calu_pkg::op_add_carry,
        calu_pkg::op_sub, calu_pkg::op_subtract_constant, calu_pkg::op_subtract_borrow_reg,
        calu_pkg::op_subtract_borrow_const, calu_pkg::op_compare,
        calu_pkg::op_compare_immediate, calu_pkg::op_compare_carry}) begin
      res_nxt = ar[7:0];
      fl_mask = 8'h2f;
      fl_val  = {2'b00, ar[12], 1'b0, ar[11], ar[10], ar[9], ar[8]};
    end
    // logic class: Z N V, carry kept
    if (op_code inside {calu_pkg::op_and, calu_pkg::op_and_constant, calu_pkg::op_or,
        calu_pkg::op_or_constant, calu_pkg::op_exclusive_or_regs, calu_pkg::op_set_mask_bits,
        calu_pkg::op_clear_mask_bits, calu_pkg::op_zero_minus_test}) begin
      res_nxt = lg;
      fl_mask = 8'h0e;
      fl_val  = {4'h0, 1'b0, lg[7], lg == 8'h00, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // hardware updates win over a software write in the same cycle
  logic [7:0] flags_nxt;
  always_comb begin
    flags_nxt = flags_r;
    if (apb_wr && paddr == calu_pkg::ADDR_FLAGS && pstrb[0]) begin
      flags_nxt = pwdata[7:0];
    end
    if (irq_take) begin
      flags_nxt[calu_pkg::FLAG_I] = 1'b0;
    end
    if (accept) begin
      flags_nxt = (flags_nxt & ~fl_mask) | (fl_val & fl_mask);
      if (op_code == calu_pkg::op_interrupt_return) begin
        flags_nxt[calu_pkg::FLAG_I] = 1'b1;
      end
    end
    flags_nxt[calu_pkg::FLAG_S] = flags_nxt[calu_pkg::FLAG_N] ^ flags_nxt[calu_pkg::FLAG_V];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= calu_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ---------------------------------------------------------------
  // program counter and sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r       <= calu_pkg::PC_RESET;
      busy_cnt_r <= 3'h0;
      op_ready_r <= 1'b1;
    end else if (accept) begin
      pc_r       <= pc_nxt;
      busy_cnt_r <= cyc_nxt - 3'h1;
      op_ready_r <= (cyc_nxt == calu_pkg::CYC_ONE);
    end else if (busy_cnt_r != 3'h0) begin
      busy_cnt_r <= busy_cnt_r - 3'h1;
      op_ready_r <= (busy_cnt_r == 3'h1);
    end
  end

  // ---------------------------------------------------------------
  // write-back and stack strobes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r       <= 8'h00;
      res_we_r    <= 1'b0;
      word_r      <= 16'h0000;
      word_we_r   <= 1'b0;
      push_we_r   <= 1'b0;
      push_data_r <= 16'h0000;
      pop_req_r   <= 1'b0;
    end else begin
      res_we_r  <= accept & res_we_nxt;
      word_we_r <= accept & word_we_nxt;
      push_we_r <= accept & push_nxt;
      pop_req_r <= accept & pop_nxt;
      if (accept) begin
        res_r       <= res_nxt;
        word_r      <= word_nxt;
        push_data_r <= pc_r + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // apb slave, answers in the first access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~apb_hit;
      unique case (paddr)
        calu_pkg::ADDR_FLAGS:  prdata_r <= {24'h000000, flags_r};
        calu_pkg::ADDR_PC:     prdata_r <= {16'h0000, pc_r};
        calu_pkg::ADDR_RESULT: prdata_r <= {24'h000000, res_r};
        default:               prdata_r <= 32'h0000_0000;
      endcase
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign op_ready  = op_ready_r;
  assign res_data  = res_r;
  assign res_we    = res_we_r;
  assign word_data = word_r;
  assign word_we   = word_we_r;
  assign pc        = pc_r;
  assign push_we   = push_we_r;
  assign push_data = push_data_r;
  assign pop_req   = pop_req_r;
  assign flags_out = flags_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold_two;
    !op_ready_r ##1 op_ready_r;
  endsequence

  sequence s_hold_three;
    !op_ready_r [*2] ##1 op_ready_r;
  endsequence

  a_zero_result: assert property (accept && res_we_nxt && !irq_take |=>
    flags_r[calu_pkg::FLAG_Z] == (res_r == 8'h00)) else $error("zero flag wrong");
  a_add_carry: assert property (accept && op_code == calu_pkg::op_add |=>
    flags_r[calu_pkg::FLAG_C] == ({1'b0, $past(opd_a)} + {1'b0, $past(opd_b)} > 9'h0ff))
    else $error("carry flag wrong");
  a_logic_keeps_carry: assert property (accept && op_code == calu_pkg::op_and && !apb_wr |=>
    $stable(flags_r[calu_pkg::FLAG_C]) && !flags_r[calu_pkg::FLAG_V])
    else $error("logic op disturbed carry");
  a_sign_xor: assert property (flags_r[calu_pkg::FLAG_S] ==
    (flags_r[calu_pkg::FLAG_N] ^ flags_r[calu_pkg::FLAG_V])) else $error("sign flag wrong");
  a_ptr_jump: assert property (accept && op_code == calu_pkg::op_pointer_jump |=>
    pc_r == $past(z_ptr) ##0 s_hold_two) else $error("pointer jump wrong");
  a_ptr_call: assert property (accept && op_code == calu_pkg::op_pointer_subroutine_call |=>
    push_we_r && push_data_r == $past(pc_r) + 16'h0001 ##0 s_hold_three)
    else $error("pointer call wrong");
  a_return_cycles: assert property (accept && op_code == calu_pkg::op_sub_return |=>
    pop_req_r && !op_ready_r ##1 !op_ready_r ##1 s_hold_two) else $error("return timing wrong");
  a_irq_clears: assert property (irq_take && !accept |=>
    !flags_r[calu_pkg::FLAG_I]) else $error("interrupt bit not cleared");
  a_branch_target: assert property (accept && is_branch && taken |=>
    pc_r == $past(pc_r) + 16'h0001 + {{4{$past(rel_offset[11])}}, $past(rel_offset)}
    ##0 s_hold_two) else $error("branch target wrong");
  a_skip_two_word: assert property (accept && skip && next_two_word |=>
    pc_r == $past(pc_r) + 16'h0003 ##0 s_hold_three) else $error("skip wrong");
  a_test_no_write: assert property (accept && op_code == calu_pkg::op_zero_minus_test |=>
    !res_we_r) else $error("test wrote back");

endmodule

`default_nettype wire

/* File: verification/calu_stack_model.sv */
`default_nettype none
module calu_stack_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        push_we,
  input  wire logic [15:0] push_data,
  input  wire logic        pop_req,
  output logic      [15:0] ret_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem_r [8];
  logic [2:0]  sp_r;
  // top of stack is shown at all times, a return takes it at its own edge
  assign ret_addr = mem_r[sp_r-3'h1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= 3'h0;
    end else if (push_we) begin
      mem_r[sp_r] <= push_data;
      sp_r <= sp_r + 3'h1;
    end else if (pop_req) begin
      sp_r <= sp_r - 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/cpu_alu_branch_unit_tb.sv */
`default_nettype none
module cpu_alu_branch_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        op_valid = 1'b0, next_two_word = 1'b0, irq_take = 1'b0;
  logic [3:0]  pstrb = 4'h0;
  logic [11:0] paddr = 12'h000, rel_offset = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0]  opd_a = 8'h00, opd_b = 8'h00, io_val = 8'h00, res_data, flags_out;
  logic [15:0] word_in = 16'h0000, z_ptr = 16'h0000, word_data, pc, push_data, ret_addr;
  logic [2:0]  sel_bit = 3'h0;
  logic        pready, pslverr, op_ready, res_we, word_we, push_we, pop_req, rwe_s, pwe_s, pop_s;
  logic        wwe_s;
  int          fail_count = 0, tests_run = 0;
  calu_pkg::calu_op_t op_code = calu_pkg::op_nop;
  always #12.5 pclk = ~pclk;
  calu_exec u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .op_valid, .op_code, .opd_a, .opd_b, .word_in, .z_ptr,
    .rel_offset, .sel_bit, .io_val, .next_two_word, .ret_addr, .irq_take, .op_ready,
    .res_data, .res_we, .word_data, .word_we, .pc, .push_we, .push_data, .pop_req, .flags_out);
  calu_stack_model u_stack (.pclk, .presetn, .push_we, .push_data, .pop_req, .ret_addr);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= {4{w}};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input calu_pkg::calu_op_t c, input logic [7:0] a, input logic [7:0] b,
                    input logic [11:0] k, input logic [15:0] z, output int n);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code <= c;
    opd_a <= a;
    opd_b <= b;
    rel_offset <= k;
    z_ptr <= z;
    next_two_word <= (a == b);
    do @(posedge pclk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    #1;
    rwe_s = res_we;
    pwe_s = push_we;
    pop_s = pop_req;
    wwe_s = word_we;
    n = 1;
    while (op_ready !== 1'b1) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, calu_pkg::ADDR_FLAGS, 32'h0, r, e);
    chk("flags", r, {24'h0, calu_pkg::FLAGS_RESET});
    apb(1'b0, 12'h00c, 32'h0, r, e);
    chk("unmapped", {r[30:0], e}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_alu();
    int n;
    op(calu_pkg::op_add, 8'hff, 8'h01, 12'h0, 16'h0, n);
    chk("add", {15'h0, rwe_s, res_data, flags_out}, 32'h00010023);
    op(calu_pkg::op_and, 8'h80, 8'hf0, 12'h0, 16'h0, n);
    chk("and", {16'h0, res_data, flags_out}, 32'h00008035);
    op(calu_pkg::op_subtract_constant, 8'h10, 8'h20, 12'h0, 16'h0, n);
    chk("subtract_constant", {16'h0, res_data, flags_out}, 32'h0000f015);
    op(calu_pkg::op_zero_minus_test, 8'h00, 8'h01, 12'h0, 16'h0, n);
    chk("tst", {23'h0, rwe_s, flags_out}, 32'h00000003);
    chk("pc_seq", {16'h0, pc}, 32'h00000004);
    $display("test alu done");
  endtask
  task automatic t_flow();
    int n;
    op(calu_pkg::op_branch_carry_set, 8'h00, 8'h01, 12'h005, 16'h0, n);
    chk("brc", {8'h0, pc, 8'(n)}, 32'h00000a02);
    op(calu_pkg::op_compare_skip_equal, 8'h33, 8'h33, 12'h0, 16'h0, n);
    chk("compare_skip_equal", {8'h0, pc, 8'(n)}, 32'h00000d03);
    op(calu_pkg::op_pointer_jump, 8'h00, 8'h01, 12'h0, 16'h0040, n);
    chk("pointer_jump", {pc, flags_out, 8'(n)}, 32'h00400302);
    op(calu_pkg::op_pointer_subroutine_call, 8'h00, 8'h01, 12'h0, 16'h0100, n);
    chk("pointer_subroutine_call", {7'h0, pwe_s, push_data, 8'(n)}, 32'h01004103);
    chk("pointer_subroutine_call_pc", {16'h0, pc}, 32'h00000100);
    op(calu_pkg::op_interrupt_return, 8'h00, 8'h01, 12'h0, 16'h0, n);
    chk("interrupt_return", {7'h0, pop_s, pc, flags_out}, 32'h01004183);
    chk("interrupt_return_cyc", n, 32'h00000004);
    op(calu_pkg::op_branch_carry_clear, 8'h00, 8'h01, 12'h005, 16'h0, n);
    chk("branch_carry_clear", {8'h0, pc, 8'(n)}, 32'h00004201);
    op(calu_pkg::op_branch_flag_set, 8'h00, 8'h01, 12'hffe, 16'h0, n);
    chk("branch_flag_set", {8'h0, pc, 8'(n)}, 32'h00004102);
    $display("test flow done");
  endtask
  task automatic t_apb();
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b0, calu_pkg::ADDR_PC, 32'h0, r, e);
    chk("pc_rd", r, 32'h41);
    apb(1'b1, calu_pkg::ADDR_FLAGS, 32'h40, r, e);
    apb(1'b0, calu_pkg::ADDR_FLAGS, 32'h0, r, e);
    chk("flags_wr", r, 32'h40);
    op(calu_pkg::op_branch_copybit_set, 8'h00, 8'h01, 12'h003, 16'h0, n);
    chk("branch_copybit_set", {8'h0, pc, 8'(n)}, 32'h00004502);
    op(calu_pkg::op_branch_signed_less, 8'h00, 8'h01, 12'h003, 16'h0, n);
    chk("branch_signed_less", {8'h0, pc, 8'(n)}, 32'h00004601);
    $display("test apb done");
  endtask
  task automatic t_more();
    logic [31:0] r;
    logic        e;
    int          n;
    @(posedge pclk);
    word_in <= 16'h7fff;
    sel_bit <= 3'h3;
    io_val  <= 8'hf7;
    op(calu_pkg::op_word_add_immediate, 8'h00, 8'h01, 12'h0, 16'h0, n);
    chk("word_add_immediate", {7'h0, wwe_s, word_data, flags_out}, 32'h0180004c);
    op(calu_pkg::op_compare, 8'h10, 8'h21, 12'h0, 16'h0, n);
    chk("cp", {23'h0, rwe_s, flags_out}, 32'h00000075);
    op(calu_pkg::op_skip_reg_bit_set, 8'h08, 8'h00, 12'h0, 16'h0, n);
    chk("skip_reg_bit_set", {8'h0, pc, 8'(n)}, 32'h00004a02);
    op(calu_pkg::op_skip_io_bit_clear, 8'h00, 8'h01, 12'h0, 16'h0, n);
    chk("skip_io_bit_clear", {pc, flags_out, 8'(n)}, 32'h004c7502);
    op(calu_pkg::op_branch_halfcarry_set, 8'h00, 8'h01, 12'h002, 16'h0, n);
    chk("branch_halfcarry_set", {8'h0, pc, 8'(n)}, 32'h00004f02);
    op(calu_pkg::op_branch_overflow_set, 8'h00, 8'h01, 12'h002, 16'h0, n);
    chk("branch_overflow_set", {8'h0, pc, 8'(n)}, 32'h00005001);
    op(calu_pkg::op_pointer_subroutine_call, 8'h00, 8'h01, 12'h0, 16'h0200, n);
    op(calu_pkg::op_sub_return, 8'h00, 8'h01, 12'h0, 16'h0, n);
    chk("ret", {7'h0, pop_s, pc, flags_out}, 32'h01005175);
    chk("ret_cyc", n, 32'h00000004);
    apb(1'b1, calu_pkg::ADDR_FLAGS, 32'h80, r, e);
    apb(1'b0, calu_pkg::ADDR_FLAGS, 32'h0, r, e);
    chk("irq_set", r, 32'h00000080);
    @(posedge pclk);
    irq_take <= 1'b1;
    @(posedge pclk);
    irq_take <= 1'b0;
    apb(1'b0, calu_pkg::ADDR_FLAGS, 32'h0, r, e);
    chk("irq_clr", r, 32'h00000000);
    $display("test more done");
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_alu();
    t_flow();
    t_apb();
    t_more();
    test_done();
  end
  // whole run is well under 400 cycles, so this only fires on a hang
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
